// file: hdl/igrc_map.vh
/*
  Constants for the input port gain-ranging control: field widths,
  reset values and gain-code limits.
  Assumes it is included by bare name from the design files.
*/
`ifndef IGRC_MAP_VH
`define IGRC_MAP_VH

// ----------------------------------------------------------------
// Field widths, delay limit and port count
// ----------------------------------------------------------------
`define IGRC_DATA_W 16
`define IGRC_CODE_W 3
`define IGRC_THR_W 10
`define IGRC_DWELL_W 20
`define IGRC_DELAY_W 6
`define IGRC_DELAY_MAX 63
`define IGRC_PORTS 4

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define IGRC_MAG_MSB 14
`define IGRC_MAG_LSB 5
`define IGRC_MAG_FULL 10'h3FF
`define IGRC_CODE_MIN 3'h0
`define IGRC_CODE_MAX 3'h7
`define IGRC_CODE_STEP 3'h1
`define IGRC_DWELL_ONE 20'h00001
`define IGRC_DELAY_ZERO 6'h00

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IGRC_RST_CODE 3'h0
`define IGRC_RST_DATA 16'h0000
`define IGRC_RST_DWELL 20'h00000
`define IGRC_RST_DELAY 6'h00

`endif

// file: hdl/igrc_port.v
/*
  Gain decision logic for one input port: threshold compare, dwell
  timer, saturating gain code and relinearization hold-off.
  Assumes the sample is already synchronised to mclk and that the
  settings are stable while gain_on is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "igrc_map.vh"

module igrc_port (
  input wire mclk,
  input wire rst_n,
  input wire [15:0] sample,
  input wire gain_on,
  input wire [9:0] upper_threshold,
  input wire [9:0] lower_threshold,
  input wire [19:0] dwell_time,
  input wire [5:0] relin_delay,
  output reg [2:0] gain_code_reg
);

  // ----------------------------------------------------------------
  // Magnitude
  // ----------------------------------------------------------------
  // Ten top bits of |x|, full scale on the most negative code
  function [9:0] igrc_mag10;
    input [15:0] x;
    reg [15:0] a;
    begin
      a = x[15] ? (~x + 16'h0001) : x;
      if (a[15])
        igrc_mag10 = `IGRC_MAG_FULL;
      else
        igrc_mag10 = a[`IGRC_MAG_MSB:`IGRC_MAG_LSB];
    end
  endfunction

  wire [9:0] mag = igrc_mag10(sample);
  wire over = (mag > upper_threshold);
  wire under = (mag < lower_threshold);

  reg [19:0] dwell_reg;
  reg dwell_run_reg;
  reg [5:0] busy_reg;
  reg gain_on_d_reg;
  wire busy = (busy_reg != `IGRC_DELAY_ZERO);

  // ----------------------------------------------------------------
  // Gain code state
  // ----------------------------------------------------------------
  // Overload steps down at once; low signal steps up after dwell
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gain_code_reg <= `IGRC_RST_CODE;
      dwell_reg <= `IGRC_RST_DWELL;
      dwell_run_reg <= 1'b0;
      busy_reg <= `IGRC_RST_DELAY;
      gain_on_d_reg <= 1'b0;
    end
    else
    begin
      gain_on_d_reg <= gain_on;
      if (!gain_on || !gain_on_d_reg)
      begin
        gain_code_reg <= `IGRC_CODE_MIN;
        dwell_run_reg <= 1'b0;
        busy_reg <= `IGRC_RST_DELAY;
      end
      else
      begin
        if (busy)
          busy_reg <= busy_reg - 6'h01;
        if (over)
        begin
          dwell_run_reg <= 1'b0;
          if (!busy && gain_code_reg != `IGRC_CODE_MIN)
          begin
            gain_code_reg <= gain_code_reg - `IGRC_CODE_STEP;
            busy_reg <= relin_delay;
          end
        end
        else if (under)
        begin
          if (!dwell_run_reg)
          begin
            dwell_reg <= dwell_time;
            dwell_run_reg <= 1'b1;
          end
          else if (dwell_reg <= `IGRC_DWELL_ONE)
          begin
            dwell_run_reg <= 1'b0;
            if (!busy && gain_code_reg != `IGRC_CODE_MAX)
            begin
              gain_code_reg <= gain_code_reg + `IGRC_CODE_STEP;
              busy_reg <= relin_delay;
            end
          end
          else
            dwell_reg <= dwell_reg - `IGRC_DWELL_ONE;
        end
        else
          dwell_run_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: hdl/igrc_top.v
/*
  Gain-ranging control for four input ports A to D: per-port gain
  decision, shared exponent pins, relinearization delay line and
  exponent scaling of the port data, with A/B and C/D pairing.
  Assumes one sample per mclk on every port; pins are asynchronous.
*/
// Operation
// - Every port has its own gain logic
// - Enable drives pins outward, else pins input
// - Pins are inputs after reset
// - Overload decrements gain code at once
// - Low signal loads the dwell counter
// - Count down dwell; increment at one
// - Rising above lower threshold abandons increment
// - Compare thresholds with ten magnitude MSBs
// - Delay code up to 63 clocks before use
// - Each code step attenuates by 6.02 dB
// - Ignore adjustments during relinearization delay
// - Enabling resets gain code to zero
// - Paired B: gain off, exponent copies A
// - Exponent k shifts data right k bits
// - A/B and C/D paired independently
`timescale 1ns/100ps
`default_nettype none
`include "igrc_map.vh"

module igrc_top (
  input wire mclk,
  input wire rst_n,
  input wire pair_ab,
  input wire pair_cd,
  input wire [15:0] port_a_data,
  input wire [15:0] port_b_data,
  input wire [15:0] port_c_data,
  input wire [15:0] port_d_data,
  input wire [2:0] port_a_exponent_gain_pins_in,
  input wire [2:0] port_b_exponent_gain_pins_in,
  input wire [2:0] port_c_exponent_gain_pins_in,
  input wire [2:0] port_d_exponent_gain_pins_in,
  output wire [2:0] port_a_exponent_gain_pins_out,
  output wire [2:0] port_b_exponent_gain_pins_out,
  output wire [2:0] port_c_exponent_gain_pins_out,
  output wire [2:0] port_d_exponent_gain_pins_out,
  output wire port_a_exponent_gain_pins_oe,
  output wire port_b_exponent_gain_pins_oe,
  output wire port_c_exponent_gain_pins_oe,
  output wire port_d_exponent_gain_pins_oe,
  input wire port_a_gain_enable,
  input wire port_b_gain_enable,
  input wire port_c_gain_enable,
  input wire port_d_gain_enable,
  input wire [9:0] port_a_upper_threshold,
  input wire [9:0] port_b_upper_threshold,
  input wire [9:0] port_c_upper_threshold,
  input wire [9:0] port_d_upper_threshold,
  input wire [9:0] port_a_lower_threshold,
  input wire [9:0] port_b_lower_threshold,
  input wire [9:0] port_c_lower_threshold,
  input wire [9:0] port_d_lower_threshold,
  input wire [19:0] port_a_dwell_time,
  input wire [19:0] port_b_dwell_time,
  input wire [19:0] port_c_dwell_time,
  input wire [19:0] port_d_dwell_time,
  input wire [5:0] port_a_relin_delay,
  input wire [5:0] port_b_relin_delay,
  input wire [5:0] port_c_relin_delay,
  input wire [5:0] port_d_relin_delay,
  output wire [2:0] port_a_exponent,
  output wire [2:0] port_b_exponent,
  output wire [2:0] port_c_exponent,
  output wire [2:0] port_d_exponent,
  output wire [15:0] port_a_scaled_data,
  output wire [15:0] port_b_scaled_data,
  output wire [15:0] port_c_scaled_data,
  output wire [15:0] port_d_scaled_data
);

  // ----------------------------------------------------------------
  // Packing of per-port ports
  // ----------------------------------------------------------------
  wire [63:0] data_in = {port_d_data, port_c_data, port_b_data, port_a_data};
  wire [11:0] pin_in = {port_d_exponent_gain_pins_in, port_c_exponent_gain_pins_in,
    port_b_exponent_gain_pins_in, port_a_exponent_gain_pins_in};
  wire [3:0] enable_in = {port_d_gain_enable, port_c_gain_enable,
    port_b_gain_enable, port_a_gain_enable};
  wire [39:0] upper_in = {port_d_upper_threshold, port_c_upper_threshold,
    port_b_upper_threshold, port_a_upper_threshold};
  wire [39:0] lower_in = {port_d_lower_threshold, port_c_lower_threshold,
    port_b_lower_threshold, port_a_lower_threshold};
  wire [79:0] dwell_in = {port_d_dwell_time, port_c_dwell_time,
    port_b_dwell_time, port_a_dwell_time};
  wire [23:0] delay_in = {port_d_relin_delay, port_c_relin_delay,
    port_b_relin_delay, port_a_relin_delay};

  // Second port of a pair is shut down when paired
  wire [3:0] shut = {pair_cd, 1'b0, pair_ab, 1'b0};

  wire [11:0] code;
  wire [11:0] exp_own;
  wire [11:0] exp_used;
  reg [3:0] gain_on_reg;
  reg [63:0] data_s1_reg;
  reg [63:0] data_s2_reg;
  reg [11:0] pin_s1_reg;
  reg [11:0] pin_s2_reg;
  wire [63:0] scaled;
  wire [11:0] exp_out;

  // ----------------------------------------------------------------
  // Pin synchronisers and enable state
  // ----------------------------------------------------------------
  // Two stages before any logic sees a pin
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_s1_reg <= 64'h0000000000000000;
      data_s2_reg <= 64'h0000000000000000;
      pin_s1_reg <= 12'h000;
      pin_s2_reg <= 12'h000;
      gain_on_reg <= 4'h0;
    end
    else
    begin
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      gain_on_reg <= enable_in & ~shut;
    end
  end

  // ----------------------------------------------------------------
  // Per-port gain logic and delay line
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `IGRC_PORTS; i = i + 1)
    begin : g_port
      reg [2:0] line_reg [0:62];
      wire [5:0] dly = delay_in[i*6 +: 6];
      wire [2:0] tap;
      integer k;

      // Independent decision logic per port
      igrc_port u_port (
        .mclk(mclk),
        .rst_n(rst_n),
        .sample(data_s2_reg[i*16 +: 16]),
        .gain_on(gain_on_reg[i]),
        .upper_threshold(upper_in[i*10 +: 10]),
        .lower_threshold(lower_in[i*10 +: 10]),
        .dwell_time(dwell_in[i*20 +: 20]),
        .relin_delay(dly),
        .gain_code_reg(code[i*3 +: 3])
      );

      // Pipeline of past gain codes, cleared while disabled
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          for (k = 0; k < `IGRC_DELAY_MAX; k = k + 1)
            line_reg[k] <= `IGRC_RST_CODE;
        end
        else
        begin
          line_reg[0] <= gain_on_reg[i] ? code[i*3 +: 3] : `IGRC_RST_CODE;
          for (k = 1; k < `IGRC_DELAY_MAX; k = k + 1)
            line_reg[k] <= line_reg[k-1];
        end
      end

      // Tap chosen by the relinearization delay
      assign tap = (dly == `IGRC_DELAY_ZERO) ? code[i*3 +: 3] : line_reg[dly - 6'h01];
      assign exp_own[i*3 +: 3] = gain_on_reg[i] ? tap : pin_s2_reg[i*3 +: 3];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Exponent selection for pairs
  // ----------------------------------------------------------------
  // Second port of a pair follows the first one
  assign exp_used[2:0] = exp_own[2:0];
  assign exp_used[5:3] = pair_ab ? exp_own[2:0] : exp_own[5:3];
  assign exp_used[8:6] = exp_own[8:6];
  assign exp_used[11:9] = pair_cd ? exp_own[8:6] : exp_own[11:9];

  // ----------------------------------------------------------------
  // Relinearization scaling
  // ----------------------------------------------------------------
  // Arithmetic shift by k gives 6.02 dB per step
  generate
    for (i = 0; i < `IGRC_PORTS; i = i + 1)
    begin : g_scale
      reg [15:0] scaled_reg;
      reg [2:0] exp_reg;
      wire [2:0] use_exp = exp_used[i*3 +: 3];

      // Per-port output registers, one process drives each
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          scaled_reg <= `IGRC_RST_DATA;
          exp_reg <= `IGRC_RST_CODE;
        end
        else
        begin
          scaled_reg <= $signed(data_s2_reg[i*16 +: 16]) >>> use_exp;
          exp_reg <= use_exp;
        end
      end

      // Gather the port slices for the outputs
      assign scaled[i*16 +: 16] = scaled_reg;
      assign exp_out[i*3 +: 3] = exp_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Only an enabled, unshut port drives its pins
  assign port_a_exponent_gain_pins_out = code[2:0];
  assign port_b_exponent_gain_pins_out = code[5:3];
  assign port_c_exponent_gain_pins_out = code[8:6];
  assign port_d_exponent_gain_pins_out = code[11:9];
  assign port_a_exponent_gain_pins_oe = gain_on_reg[0];
  assign port_b_exponent_gain_pins_oe = gain_on_reg[1];
  assign port_c_exponent_gain_pins_oe = gain_on_reg[2];
  assign port_d_exponent_gain_pins_oe = gain_on_reg[3];
  assign port_a_exponent = exp_out[2:0];
  assign port_b_exponent = exp_out[5:3];
  assign port_c_exponent = exp_out[8:6];
  assign port_d_exponent = exp_out[11:9];
  assign port_a_scaled_data = scaled[15:0];
  assign port_b_scaled_data = scaled[31:16];
  assign port_c_scaled_data = scaled[47:32];
  assign port_d_scaled_data = scaled[63:48];

endmodule
`default_nettype wire

// file: sim/igrc_top_asserts.sv
/* Concurrent checks on the igrc_top ports: port A gain loop, pin
   direction, exponent scaling and pairing.
   Assumes one clock, mclk, and the asynchronous reset rst_n. */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module igrc_chk (
  input wire mclk,
  input wire rst_n,
  input wire pair_ab,
  input wire pair_cd,
  input wire [15:0] port_a_data,
  input wire [15:0] port_b_data,
  input wire [2:0] port_a_exponent_gain_pins_in,
  input wire [2:0] port_a_exponent_gain_pins_out,
  input wire port_a_exponent_gain_pins_oe,
  input wire port_b_exponent_gain_pins_oe,
  input wire port_a_gain_enable,
  input wire [9:0] port_a_upper_threshold,
  input wire [9:0] port_a_lower_threshold,
  input wire [5:0] port_a_relin_delay,
  input wire [2:0] port_a_exponent,
  input wire [2:0] port_b_exponent,
  input wire [2:0] port_c_exponent,
  input wire [2:0] port_d_exponent,
  input wire [15:0] port_b_scaled_data
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reg [2:0] prev_reg;
  reg [6:0] since_reg;
  // Magnitude of port A, top ten bits, most negative saturates
  wire [15:0] abs_a = port_a_data[15] ? 16'h0000 - port_a_data : port_a_data;
  wire [9:0] mag_a = (port_a_data == 16'h8000) ? 10'h3FF : abs_a[14:5];
  wire over_a = mag_a > port_a_upper_threshold;
  wire under_a = mag_a < port_a_lower_threshold;
  wire [2:0] code_a = port_a_exponent_gain_pins_out;
  wire oe_a = port_a_exponent_gain_pins_oe;
  wire moved = oe_a && code_a != prev_reg;
  // Last code and cycles since it last moved
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      prev_reg <= 3'h0;
      since_reg <= 7'h00;
    end
    else
    begin
      prev_reg <= code_a;
      if (moved)
        since_reg <= 7'h01;
      else if (since_reg != 7'h7F)
        since_reg <= since_reg + 7'h01;
    end
  oe_follow_a: assert property (1'b1 |=> oe_a == $past(port_a_gain_enable))
    else $error("pin direction does not follow enable");
  zero_on_enable_a: assert property ($rose(oe_a) |=> code_a == 3'h0)
    else $error("code not cleared on enable");
  code_step_a: assert property (moved && $past(oe_a, 2) |->
    {1'b0, code_a} == {1'b0, prev_reg} + 4'h1 || {1'b0, code_a} + 4'h1 == {1'b0, prev_reg})
    else $error("code moved by more than one step");
  dec_cause_a: assert property (moved && $past(oe_a, 2) && code_a < prev_reg |->
    $past(over_a, 3)) else $error("decrement without overload");
  inc_cause_a: assert property (moved && $past(oe_a, 2) && code_a > prev_reg |->
    $past(under_a, 3)) else $error("increment without low signal");
  hold_off_a: assert property (moved && $past(oe_a, 2) |->
    since_reg >= port_a_relin_delay) else $error("change inside hold-off");
  pin_exp_a: assert property (!oe_a [*4] |->
    port_a_exponent == $past(port_a_exponent_gain_pins_in, 3)) else $error("input exponent lost");
  scale_b_a: assert property ($signed(port_b_scaled_data) ==
    ($signed($past(port_b_data, 3)) >>> port_b_exponent)) else $error("wrong scaling");
  pair_copy_a: assert property (pair_ab [*4] |-> port_b_exponent == port_a_exponent)
    else $error("paired exponent differs");
  pair_shut_a: assert property (pair_ab |=> !port_b_exponent_gain_pins_oe)
    else $error("paired port drives pins");
  pair_cd_a: assert property (pair_cd [*4] |-> port_d_exponent == port_c_exponent)
    else $error("paired exponent differs");
  cover property (moved && code_a < prev_reg);
  cover property (oe_a && code_a == 3'h7);
  cover property (pair_cd && !pair_ab);
endmodule

bind igrc_top igrc_chk chk (.*);
`default_nettype wire

// file: sim/igrc_gain_stage.sv
/* External gain stage model: 6 dB per code step, clamped at full
   scale. Resolves port A's shared exponent pins for both sides. */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Gain stage
// ----------------------------------------------------------------
module igrc_gain_stage (
  input wire logic [2:0] code_out,
  input wire logic code_oe,
  input wire logic [2:0] adc_exp,
  input wire logic [15:0] level,
  output logic [2:0] pin_level,
  output logic [15:0] amp_data
);
  logic [31:0] boosted;
  // Device drives the pins when enabled, else the converter does
  assign pin_level = code_oe ? code_out : adc_exp;
  // Doubling per step, held at full scale
  assign boosted = {16'h0000, level} << pin_level;
  assign amp_data = (boosted > 32'h00007FFF) ? 16'h7FFF : boosted[15:0];
endmodule
`default_nettype wire

// file: sim/igrc_top_test.sv
/* Testbench for igrc_top: gain stage model on port A, the bench
   feeds the other ports' data and exponent pins. */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module igrc_top_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic pair_ab = 1'b0, pair_cd = 1'b0, en_a = 1'b0, en_c = 1'b0;
  logic [15:0] level = 16'h0000, dat_o = 16'h0000;
  logic [15:0] a_data, a_sc, b_sc, c_sc, d_sc;
  logic [2:0] ext = 3'h0;
  logic [9:0] upper = 10'h000, lower = 10'h000;
  logic [19:0] dwell = 20'h00000;
  logic [5:0] relin = 6'h00;
  logic [2:0] a_pin, a_out, b_out, c_out, d_out, a_exp, b_exp, d_exp;
  logic a_oe, b_oe, c_oe, d_oe;
  int errors = 0, tests_run = 0, n;
  always #50 mclk = ~mclk;
  igrc_gain_stage amp (.code_out(a_out), .code_oe(a_oe), .adc_exp(ext), .level(level),
    .pin_level(a_pin), .amp_data(a_data));
  igrc_top uut (.mclk(mclk), .rst_n(rst_n), .pair_ab(pair_ab), .pair_cd(pair_cd),
    .port_a_data(a_data), .port_b_data(dat_o), .port_c_data(dat_o), .port_d_data(dat_o),
    .port_a_exponent_gain_pins_in(a_pin), .port_b_exponent_gain_pins_in(b_oe ? b_out : ext),
    .port_c_exponent_gain_pins_in(c_oe ? c_out : ext),
    .port_d_exponent_gain_pins_in(d_oe ? d_out : ext),
    .port_a_exponent_gain_pins_out(a_out), .port_b_exponent_gain_pins_out(b_out),
    .port_c_exponent_gain_pins_out(c_out), .port_d_exponent_gain_pins_out(d_out),
    .port_a_exponent_gain_pins_oe(a_oe), .port_b_exponent_gain_pins_oe(b_oe),
    .port_c_exponent_gain_pins_oe(c_oe), .port_d_exponent_gain_pins_oe(d_oe),
    .port_a_gain_enable(en_a), .port_b_gain_enable(en_c), .port_c_gain_enable(en_c),
    .port_d_gain_enable(en_c), .port_a_upper_threshold(upper), .port_b_upper_threshold(upper),
    .port_c_upper_threshold(upper), .port_d_upper_threshold(upper),
    .port_a_lower_threshold(lower), .port_b_lower_threshold(lower),
    .port_c_lower_threshold(lower), .port_d_lower_threshold(lower),
    .port_a_dwell_time(dwell), .port_b_dwell_time(dwell), .port_c_dwell_time(dwell),
    .port_d_dwell_time(dwell), .port_a_relin_delay(relin), .port_b_relin_delay(relin),
    .port_c_relin_delay(relin), .port_d_relin_delay(relin), .port_a_exponent(a_exp),
    .port_b_exponent(b_exp), .port_c_exponent(), .port_d_exponent(d_exp),
    .port_a_scaled_data(a_sc), .port_b_scaled_data(b_sc), .port_c_scaled_data(c_sc),
    .port_d_scaled_data(d_sc));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cycles(input int c);
    repeat (c) @(negedge mclk);
  endtask
  // Bounded wait for port A's code, cycles taken returned
  task automatic wait_code(input logic [2:0] want, output int t);
    for (t = 0; t < 2000 && a_out !== want; t++) @(negedge mclk);
    if (t == 2000)
    begin
      errors++;
      finish_test();
    end
  endtask
  // Main sequence
  initial
  begin
    cycles(20);
    rst_n = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      ext = k[2:0];
      dat_o = 16'hA5A0;
      cycles(5);
      check(a_oe, 1'b0);
      check(b_exp, ext);
      check(b_sc, 16'($signed(16'hA5A0) >>> k));
      check(c_sc, 16'($signed(16'hA5A0) >>> k));
      check(d_sc, 16'($signed(16'hA5A0) >>> k));
    end
    $display("test input exponent done");
    upper = 10'h200;
    lower = 10'h040;
    dwell = 20'h00014;
    relin = 6'h04;
    level = 16'h0100;
    cycles(2);
    en_a = 1'b1;
    wait_code(3'h1, n);
    check(n >= 18 && n <= 26, 1'b1);
    wait_code(3'h3, n);
    for (n = 0; n < 99 && a_exp !== 3'h3; n++) @(negedge mclk);
    check(n, 5);
    if (n == 99) finish_test();
    cycles(40);
    check(a_out, 3'h3);
    check(a_sc, 16'h0100);
    $display("test dwell ramp done");
    level = 16'h0C00;
    wait_code(3'h2, n);
    check(n <= 6, 1'b1);
    cycles(50);
    check(a_out, 3'h2);
    level = 16'h7FFF;
    wait_code(3'h0, n);
    cycles(100);
    check(a_out, 3'h0);
    level = 16'h0001;
    wait_code(3'h7, n);
    cycles(200);
    check(a_out, 3'h7);
    $display("test limits done");
    en_a = 1'b0;
    cycles(3);
    check(a_oe, 1'b0);
    level = 16'h7FFF;
    en_a = 1'b1;
    cycles(3);
    check(a_out, 3'h0);
    repeat (20)
    begin
      level = 16'h0001;
      cycles(10);
      level = 16'h1000;
      cycles(10);
    end
    check(a_out, 3'h0);
    $display("test enable and abandon done");
    pair_ab = 1'b1;
    pair_cd = 1'b1;
    en_c = 1'b1;
    en_a = 1'b0;
    ext = 3'h3;
    dat_o = 16'h0000;
    cycles(10);
    check(b_oe, 1'b0);
    check(d_oe, 1'b0);
    check(c_oe, 1'b1);
    check(b_exp, 3'h3);
    pair_ab = 1'b0;
    ext = 3'h5;
    cycles(300);
    check(d_exp, 3'h7);
    check(a_exp, 3'h5);
    check(b_exp, 3'h7);
    $display("test pairing done");
    rst_n = 1'b0;
    cycles(3);
    check(c_oe, 1'b0);
    check(b_oe, 1'b0);
    rst_n = 1'b1;
    cycles(3);
    check(c_oe, 1'b1);
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire
